// ### include/bcpf_pkg.sv
package bcpf_pkg;
   localparam logic [23:0] SYNC_WORD = 24'hfa_f320;
   localparam logic [15:0] FILL_INFO = 16'haaaa;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam int WORD_BITS = 24;
   localparam int INFO_BITS = 16;
   localparam int FRAME_MIN = 128;
   localparam int FRAME_MAX = 511;
   localparam int FRAME_DEF = 128;
   localparam int MAX_TRACKS = 4;
   localparam int SPREAD_4 = 24 / 4;
   localparam int SPREAD_2 = 24 / 2;
   localparam int SPREAD_3 = 24 / 3;
   localparam logic [3:0] LBL_FILL = 4'h0;
   localparam logic [3:0] LBL_CRC = 4'h0;
   localparam logic [3:0] LBL_TIME_HI = 4'h0;
   localparam logic [3:0] LBL_TIME_LO = 4'h0;
   localparam logic [3:0] LBL_TIME_US = 4'h0;

   typedef struct packed {
      logic [3:0] upper;
      logic [3:0] content;
      logic [15:0] info;
   } bcpf_word_t;

   typedef struct packed {
      logic syncErr;
      logic manchErr;
      logic parityErr;
      logic gapErr;
      logic countErr;
      logic wordCountErr;
      logic modeCodeErr;
   } bcpf_fault_t;

   typedef enum logic [2:0] {
      SL_SYNC = 3'b000,
      SL_THI = 3'b001,
      SL_TLO = 3'b010,
      SL_TUS = 3'b011,
      SL_DATA = 3'b100,
      SL_CRC = 3'b101
   } bcpf_slot_t;
endpackage

// ### rtl/bcpf_framer.sv
// Function
// - frames open with sync word FAF320
// - optional time words follow sync in order
// - no time: data directly after sync
// - no check word: last slot data
// - fill may be omitted for buffered recorder
// - per-track streams offset by 24/count bits
// - track count per bus, at most four
// - every track carries the sync word
// - fixed equal frame length on all tracks
// - serialise msb first
// - check word on every track frame
// - four tracks: time words spread per track
// - fewer tracks: words rotate across tracks
// - no time: data follows each track sync
// - tape output coded RNRZ-L or Bi-phase-L
// - monitor only, never drives the bus
// - word faults are bus errors, protocol not
// - time tags may slip into next frame
// - input buffering prevents captured data loss
// - frame length 128 to 511 words
// - fill words carry AAAA
// - 24-bit words with labels and info field
// - CRC-16 x16+x15+x2+1 over info fields
`timescale 1ns/1ps
`default_nettype none
module bcpf_framer #(
   parameter int FRAME_LEN = bcpf_pkg::FRAME_DEF
) (
   // clock, reset
   input wire logic mclk,
   input wire logic srst,
   // configuration
   input wire logic timeEn,
   input wire logic crcEn,
   input wire logic fillEn,
   input wire logic biphaseSel,
   input wire logic [2:0] trackCount,
   input wire logic [8:0] frameLen,
   input wire logic [3:0] busLabel,
   input wire logic bitTick,
   // time source
   input wire logic [15:0] timeHi,
   input wire logic [15:0] timeLo,
   input wire logic [15:0] timeUs,
   // captured bus words
   input wire logic inValid,
   output logic inReady,
   input wire bcpf_pkg::bcpf_word_t inWord,
   input wire bcpf_pkg::bcpf_fault_t inFault,
   // track outputs
   output logic [3:0] trackOut,
   output logic [3:0] trackActive,
   output logic busError,
   output logic frameStart
);
   function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'b0} ^ bcpf_pkg::CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   function automatic logic wordErr(input bcpf_pkg::bcpf_fault_t f);
      return f.syncErr | f.manchErr | f.parityErr | f.gapErr | f.countErr;
   endfunction

   // config latched per frame
   logic [2:0] tkCnt;
   logic [8:0] fLen;
   assign tkCnt = (trackCount == 3'd0) ? 3'd1 :
                  (trackCount > 3'd4) ? 3'd4 : trackCount;
   assign fLen = (frameLen < 9'(bcpf_pkg::FRAME_MIN)) ? 9'(FRAME_LEN) : frameLen;

   // two-entry input buffer
   bcpf_pkg::bcpf_word_t bufMem [2];
   logic [1:0] bufCnt_q;
   logic [1:0] bufCntNext;
   logic bufWr_q, bufRd_q;
   logic bufPop, bufPush;
   assign bufPush = inValid && inReady;
   assign bufCntNext = bufCnt_q + 2'(bufPush) - 2'(bufPop);
   logic errFlag_q;
   always_ff @(posedge mclk) begin
      if (srst) begin
         bufCnt_q <= 2'd0;
         bufWr_q <= 1'b0;
         bufRd_q <= 1'b0;
         inReady <= 1'b1;
      end else begin
         inReady <= (bufCntNext != 2'd2);
         if (bufPush) begin
            bufMem[bufWr_q] <= inWord;
            bufWr_q <= ~bufWr_q;
         end
         if (bufPop) begin
            bufRd_q <= ~bufRd_q;
         end
         bufCnt_q <= bufCntNext;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         errFlag_q <= 1'b0;
      end else begin
         errFlag_q <= bufPush && wordErr(inFault);
      end
   end
   assign busError = errFlag_q;

   // frame sequencing
   logic [8:0] wordIdx_q;
   logic [2:0] trkIdx_q;
   logic [4:0] bitIdx_q;
   logic [23:0] shReg_q [4];
   logic [3:0] loaded_q;
   logic [15:0] crc_q [4];
   logic [15:0] tHi_q, tLo_q, tUs_q;
   logic [2:0] latTk_q;
   logic [8:0] latLen_q;
   logic latTime_q, latCrc_q;
   logic wordTick;
   logic [23:0] nextWord;
   logic [1:0] slotTrk;
   logic takeData;
   logic lastSlot;
   logic [8:0] slotNo;
   logic frameStart_q;

   assign slotNo = wordIdx_q;
   assign lastSlot = (slotNo == latLen_q - 9'd1);
   assign slotTrk = trkIdx_q[1:0];

   always_comb begin
      nextWord = {busLabel, bcpf_pkg::LBL_FILL, bcpf_pkg::FILL_INFO};
      takeData = 1'b0;
      if (slotNo == 9'd0) begin
         nextWord = bcpf_pkg::SYNC_WORD;
      end else if (latCrc_q && lastSlot) begin
         nextWord = {busLabel, bcpf_pkg::LBL_CRC, crc_q[slotTrk]};
      end else if (latTime_q && slotNo == 9'd1 && ({1'b0, slotTrk} + 3'd1) <= 3'd3 &&
                   latTk_q == 3'd4) begin
         unique case (slotTrk)
            2'd0: nextWord = {busLabel, bcpf_pkg::LBL_TIME_HI, tHi_q};
            2'd1: nextWord = {busLabel, bcpf_pkg::LBL_TIME_LO, tLo_q};
            default: nextWord = {busLabel, bcpf_pkg::LBL_TIME_US, tUs_q};
         endcase
      end else if (latTime_q && latTk_q != 3'd4 && latTk_q == 3'd1 && slotNo <= 9'd3) begin
         unique case (slotNo[1:0])
            2'd1: nextWord = {busLabel, bcpf_pkg::LBL_TIME_HI, tHi_q};
            2'd2: nextWord = {busLabel, bcpf_pkg::LBL_TIME_LO, tLo_q};
            default: nextWord = {busLabel, bcpf_pkg::LBL_TIME_US, tUs_q};
         endcase
      end else if (latTime_q && latTk_q != 3'd4 && latTk_q != 3'd1 && slotNo <= 9'd2 &&
                   ((slotNo - 9'd1) * 9'(latTk_q) + 9'(slotTrk)) < 9'd3) begin
         unique case (2'((slotNo - 9'd1) * 9'(latTk_q) + 9'(slotTrk)))
            2'd0: nextWord = {busLabel, bcpf_pkg::LBL_TIME_HI, tHi_q};
            2'd1: nextWord = {busLabel, bcpf_pkg::LBL_TIME_LO, tLo_q};
            default: nextWord = {busLabel, bcpf_pkg::LBL_TIME_US, tUs_q};
         endcase
      end else if (bufCnt_q != 2'd0) begin
         nextWord = bufMem[bufRd_q];
         takeData = 1'b1;
      end
   end

   // words load when the shifter of the current track needs one
   logic stallFill;
   logic halfPh_q;
   logic bitGo;
   assign stallFill = !fillEn && !takeData && slotNo != 9'd0 && bitIdx_q == 5'd0 &&
                      !(latCrc_q && lastSlot) && nextWord[19:16] == bcpf_pkg::LBL_FILL &&
                      nextWord[15:0] == bcpf_pkg::FILL_INFO;
   // bitTick marks half bits; a bit starts on the first half
   assign bitGo = bitTick && !halfPh_q && !stallFill;
   assign wordTick = bitGo && (bitIdx_q == 5'd0);
   assign bufPop = wordTick && takeData;

   always_ff @(posedge mclk) begin
      if (srst) begin
         halfPh_q <= 1'b0;
      end else if (bitTick && (halfPh_q || !stallFill)) begin
         halfPh_q <= ~halfPh_q;
      end
   end

   // bit position counter, offset by 24/count per track
   always_ff @(posedge mclk) begin
      if (srst) begin
         bitIdx_q <= 5'd0;
      end else if (bitGo) begin
         bitIdx_q <= (bitIdx_q == 5'(bcpf_pkg::SPREAD_4) - 5'd1 && latTk_q == 3'd4) ? 5'd0 :
                     (bitIdx_q == 5'(bcpf_pkg::SPREAD_3) - 5'd1 && latTk_q == 3'd3) ? 5'd0 :
                     (bitIdx_q == 5'(bcpf_pkg::SPREAD_2) - 5'd1 && latTk_q == 3'd2) ? 5'd0 :
                     (bitIdx_q == 5'(bcpf_pkg::WORD_BITS) - 5'd1) ? 5'd0 :
                     bitIdx_q + 5'd1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wordIdx_q <= 9'd0;
         trkIdx_q <= 3'd0;
         latTk_q <= 3'd1;
         latLen_q <= 9'(FRAME_LEN);
         latTime_q <= 1'b0;
         latCrc_q <= 1'b0;
         tHi_q <= 16'h0000;
         tLo_q <= 16'h0000;
         tUs_q <= 16'h0000;
         frameStart_q <= 1'b0;
      end else begin
         frameStart_q <= 1'b0;
         if (wordTick) begin
            if (trkIdx_q == latTk_q - 3'd1) begin
               trkIdx_q <= 3'd0;
               if (lastSlot) begin
                  wordIdx_q <= 9'd0;
                  latTk_q <= tkCnt;
                  latLen_q <= fLen;
                  latTime_q <= timeEn;
                  latCrc_q <= crcEn;
                  tHi_q <= timeHi;
                  tLo_q <= timeLo;
                  tUs_q <= timeUs;
                  frameStart_q <= 1'b1;
               end else begin
                  wordIdx_q <= wordIdx_q + 9'd1;
               end
            end else begin
               trkIdx_q <= trkIdx_q + 3'd1;
            end
         end
      end
   end
   assign frameStart = frameStart_q;

   // per-track shifters and running check
   logic [3:0] rnrzQ, biQ, outQ;
   logic [14:0] prbs_q [4];
   always_ff @(posedge mclk) begin
      if (srst) begin
         loaded_q <= 4'h0;
         outQ <= 4'h0;
         biQ <= 4'h0;
         for (int t = 0; t < 4; t++) begin
            shReg_q[t] <= 24'h00_0000;
            crc_q[t] <= bcpf_pkg::CRC_INIT;
            prbs_q[t] <= 15'h7fff;
         end
      end else begin
         if (wordTick) begin
            if (slotNo == 9'd0) begin
               crc_q[slotTrk] <= bcpf_pkg::CRC_INIT;
            end else begin
               crc_q[slotTrk] <= crcStep(crc_q[slotTrk], nextWord[15:0]);
            end
         end
         if (bitGo) begin
            for (int t = 0; t < 4; t++) begin
               if (wordTick && 2'(t) == slotTrk) begin
                  // new word: its msb goes out now, rest waits in the shifter
                  shReg_q[t] <= {nextWord[22:0], 1'b0};
                  loaded_q[t] <= 1'b1;
                  prbs_q[t] <= {prbs_q[t][13:0], prbs_q[t][14] ^ prbs_q[t][13]};
                  outQ[t] <= biphaseSel ? nextWord[23] : (nextWord[23] ^ prbs_q[t][14]);
                  biQ[t] <= biphaseSel;
               end else if (3'(t) < latTk_q && loaded_q[t]) begin
                  shReg_q[t] <= {shReg_q[t][22:0], 1'b0};
                  prbs_q[t] <= {prbs_q[t][13:0], prbs_q[t][14] ^ prbs_q[t][13]};
                  outQ[t] <= biphaseSel ? shReg_q[t][23] :
                             (shReg_q[t][23] ^ prbs_q[t][14]);
                  biQ[t] <= biphaseSel;
               end
            end
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         trackOut <= 4'h0;
         trackActive <= 4'h0;
      end else begin
         if (bitTick) begin
            // bi-phase-l: bit in first half, inverse in second
            trackOut <= outQ ^ (biQ & {4{!halfPh_q}});
         end
         trackActive <= loaded_q;
      end
   end

   fault_class_a: assert property (@(posedge mclk) disable iff (srst)
      (bufPush && inFault.wordCountErr && !wordErr(inFault)) |=> !busError)
      else $error("protocol fault flagged as bus error");
   buf_bound_a: assert property (@(posedge mclk) disable iff (srst)
      bufCnt_q <= 2'd2)
      else $error("buffer overfilled");
   sync_first_a: assert property (@(posedge mclk) disable iff (srst)
      (wordTick && slotNo == 9'd0) |-> nextWord == bcpf_pkg::SYNC_WORD)
      else $error("frame without sync");
   track_limit_a: assert property (@(posedge mclk) disable iff (srst)
      latTk_q >= 3'd1 && latTk_q <= 3'd4)
      else $error("track count out of range");
   len_range_a: assert property (@(posedge mclk) disable iff (srst)
      latLen_q >= 9'd128)
      else $error("frame too short");
   ready_full_a: assert property (@(posedge mclk) disable iff (srst)
      (bufCnt_q == 2'd2) |-> !inReady)
      else $error("ready while full");
   crc_slot_a: assert property (@(posedge mclk) disable iff (srst)
      (wordTick && latCrc_q && lastSlot) |-> !takeData)
      else $error("data in check slot");
   time_hold_a: assert property (@(posedge mclk) disable iff (srst)
      !$stable(tHi_q) |-> frameStart_q)
      else $error("time changed mid frame");
endmodule
`default_nettype wire

// ### tb/bcpf_recorder_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcpf_recorder_model #(
   parameter logic [3:0] LABEL = 4'h5
) (
   // clock, reset
   input wire logic mclk,
   input wire logic srst,
   // serial tracks
   input wire logic bitTick,
   input wire logic [3:0] trackOut,
   // observations
   output int syncCnt[4],
   output int syncAt[4],
   output int fillCnt,
   output int tickCnt
);
   logic [47:0] shift[4];
   logic [47:0] nxt;
   logic ok;
   logic [23:0] w;
   // bi-phase-l halves decoded into one word, msb first
   always @(posedge mclk) begin
      if (srst) begin
         tickCnt <= 0;
         fillCnt <= 0;
         for (int k = 0; k < 4; k++) begin
            shift[k] = '0;
            syncCnt[k] <= 0;
            syncAt[k] <= 0;
         end
      end else if (bitTick) begin
         tickCnt <= tickCnt + 1;
         for (int k = 0; k < 4; k++) begin
            nxt = {shift[k][46:0], trackOut[k]};
            shift[k] = nxt;
            ok = 1'b1;
            for (int i = 0; i < 24; i++) begin
               ok &= nxt[47 - 2 * i] != nxt[46 - 2 * i];
               w[23 - i] = nxt[47 - 2 * i];
            end
            if (ok && w == bcpf_pkg::SYNC_WORD) begin
               syncCnt[k] <= syncCnt[k] + 1;
               syncAt[k] <= tickCnt;
            end
            if (k == 0 && ok && w == {LABEL, bcpf_pkg::LBL_FILL, bcpf_pkg::FILL_INFO}) begin
               fillCnt <= fillCnt + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_bcpf_framer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bcpf_framer;
   logic mclk, srst, timeEn, crcEn, fillEn, biphaseSel, bitTick, inValid;
   logic [2:0] trackCount;
   logic [15:0] timeHi, timeLo, timeUs;
   bcpf_pkg::bcpf_word_t inWord;
   bcpf_pkg::bcpf_fault_t inFault;
   logic inReady, busError, frameStart;
   logic [3:0] trackOut, trackActive;
   int syncCnt[4], syncAt[4], fillCnt, tickCnt;
   int err_total = 0;
   int n_compared = 0;
   int fsCnt = 0;
   always @(posedge mclk) begin
      if (frameStart === 1'b1)
         fsCnt <= fsCnt + 1;
   end
   bcpf_framer #(.FRAME_LEN(128)) dut (.mclk(mclk), .srst(srst), .timeEn(timeEn),
      .crcEn(crcEn), .fillEn(fillEn), .biphaseSel(biphaseSel), .trackCount(trackCount),
      .frameLen(9'h000), .busLabel(4'h5), .bitTick(bitTick), .timeHi(timeHi),
      .timeLo(timeLo), .timeUs(timeUs), .inValid(inValid), .inReady(inReady),
      .inWord(inWord), .inFault(inFault), .trackOut(trackOut), .trackActive(trackActive),
      .busError(busError), .frameStart(frameStart));
   bcpf_recorder_model #(.LABEL(4'h5)) rec (.mclk(mclk), .srst(srst), .bitTick(bitTick),
      .trackOut(trackOut), .syncCnt(syncCnt), .syncAt(syncAt), .fillCnt(fillCnt),
      .tickCnt(tickCnt));
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic do_reset(input logic [2:0] tc, input logic fe);
      @(posedge mclk);
      srst <= 1;
      trackCount <= tc;
      fillEn <= fe;
      repeat (5) @(posedge mclk);
      srst <= 0;
   endtask
   task automatic send(input logic [6:0] f, output logic err);
      @(posedge mclk);
      inValid <= 1;
      inWord <= {4'h5, 4'h9, 16'h1234};
      inFault <= bcpf_pkg::bcpf_fault_t'(f);
      for (int n = 0; n < 400; n++) begin
         @(negedge mclk);
         if (inReady === 1'b1)
            break;
      end
      @(posedge mclk);
      inValid <= 0;
      @(negedge mclk);
      err = busError;
      @(negedge mclk);
      err = (err === 1'b1) || (busError === 1'b1);
   endtask
   task automatic t_faults();
      logic e;
      for (int i = 0; i < 7; i++) begin
         send(7'h40 >> i, e);
         cmp(e, i < 5);
      end
   endtask
   task automatic t_buffer();
      int taken;
      taken = 0;
      do_reset(3'h1, 1);
      @(posedge mclk);
      bitTick <= 0;
      inValid <= 1;
      inFault <= '0;
      repeat (10) begin
         @(negedge mclk);
         if (inReady === 1'b1)
            taken++;
      end
      cmp(inReady, 0);
      cmp(taken, 2);
      @(posedge mclk);
      inValid <= 0;
      bitTick <= 1;
   endtask
   task automatic t_single();
      do_reset(3'h1, 1);
      for (int n = 0; n < 20000 && syncCnt[0] < 2; n++)
         @(posedge mclk);
      cmp(syncCnt[0] >= 2, 1);
      cmp(trackActive, 4'h1);
      cmp(fillCnt > 0, 1);
      for (int n = 0; n < 20000 && syncCnt[0] < 3; n++)
         @(posedge mclk);
      cmp(syncCnt[0] >= 3, 1);
   endtask
   task automatic t_frame_len();
      int a;
      int f;
      do_reset(3'h1, 1);
      for (int n = 0; n < 20000 && syncCnt[0] < 1; n++)
         @(posedge mclk);
      a = syncAt[0];
      f = fsCnt;
      for (int n = 0; n < 20000 && syncCnt[0] < 2; n++)
         @(posedge mclk);
      cmp(syncAt[0] - a, 128 * 24 * 2);
      cmp(fsCnt - f, 1);
   endtask
   task automatic t_spread();
      for (int tc = 2; tc <= 4; tc++) begin
         do_reset(tc[2:0], 1);
         for (int n = 0; n < 20000 && syncCnt[tc - 1] < 1; n++)
            @(posedge mclk);
         for (int k = 1; k < tc; k++) begin
            cmp(syncCnt[k] >= 1, 1);
            cmp(syncAt[k] - syncAt[k - 1], 24 / tc * 2);
         end
      end
   endtask
   task automatic t_nofill();
      do_reset(3'h1, 0);
      repeat (3000) @(posedge mclk);
      cmp(fillCnt, 0);
   endtask
   initial begin
      srst = 1;
      timeEn = 0;
      crcEn = 0;
      fillEn = 1;
      biphaseSel = 1;
      bitTick = 1;
      trackCount = 3'h1;
      timeHi = 16'h1111;
      timeLo = 16'h2222;
      timeUs = 16'h3333;
      inValid = 0;
      inWord = '0;
      inFault = '0;
      do_reset(3'h1, 1);
      @(negedge mclk);
      cmp({busError, frameStart, trackActive}, 0);
      t_faults();
      t_buffer();
      t_single();
      t_frame_len();
      t_spread();
      t_nofill();
      close_out();
   end
   initial begin
      #(25 * 100000);
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
